// File: src/vimu_pkg.sv
// Function
// - Normal masked status bits 31:2 are raw normal status ANDed with normal enable.
// - With vectoring off, any normal masked status bit set raises the normal request line.
// - Vectored mode off: no priority encoding, vector index reads zero.
// - Fast masked status bits 31:2 are raw fast status ANDed with fast enable.
// - OR of fast masked bits 31:1 drives fast request and bit 0 of both classes.
// - Writing 1 to fast enable sets it and clears the same normal enable bit.
// - Writing 1 to normal enable clears the same fast enable bit.
// - Raw fast status follows the peripheral lines; read only.
// - Writing 0 to fast enable leaves that bit unchanged.
// - Ones written to fast enable-clear clear those fast enable bits only.
// - Software interrupts bypass masking, landing in raw and masked status.
// - Software config bit 2 sets or clears fast status bit 1.
// - Software config bit 1 sets or clears normal status bit 1.
// - Control bit 0 enables normal vectoring; bit 1 is stored and read back but unused; both reset off.
// - Vectored mode nests eight levels, normal class only; fast always beats normal.
// - Sources 1, 3-6 and 10-19 have a priority 0 to 7 in three registers; 0 most urgent.
// - Vector base holds 16 writable bits; bits 31:16 read zero.
// - Vector readout: zeros, base in 22:7, winning index in 6:2, zeros 1:0.
// - Raw normal status follows the peripheral lines; read only.
// - Writing 1 to normal enable sets it; writing 0 has no effect.
// - Ones written to normal enable-clear clear those normal enable bits only.
// - A set nesting status bit blocks normal sources of that level and lower.
package vimu_pkg;
  localparam logic [31:0] OFF_NMSK = 32'hFFFF0000;
  localparam logic [31:0] OFF_NRAW = 32'hFFFF0004;
  localparam logic [31:0] OFF_NEN = 32'hFFFF0008;
  localparam logic [31:0] OFF_NCLR = 32'hFFFF000C;
  localparam logic [31:0] OFF_SWI = 32'hFFFF0010;
  localparam logic [31:0] OFF_BASE = 32'hFFFF0014;
  localparam logic [31:0] OFF_VEC = 32'hFFFF001C;
  localparam logic [31:0] OFF_PA = 32'hFFFF0020;
  localparam logic [31:0] OFF_PB = 32'hFFFF0024;
  localparam logic [31:0] OFF_PC = 32'hFFFF0028;
  localparam logic [31:0] OFF_CTL = 32'hFFFF0030;
  localparam logic [31:0] OFF_NEST = 32'hFFFF003C;
  localparam logic [31:0] OFF_FMSK = 32'hFFFF0100;
  localparam logic [31:0] OFF_FRAW = 32'hFFFF0104;
  localparam logic [31:0] OFF_FEN = 32'hFFFF0108;
  localparam logic [31:0] OFF_FCLR = 32'hFFFF010C;
  // Field positions
  localparam int SWI_NORM_BIT = 1;
  localparam int SWI_FAST_BIT = 2;
  localparam int CTL_NORM_BIT = 0;
  localparam int CTL_FAST_BIT = 1;
  localparam int VEC_IDX_LSB = 2;
  localparam int VEC_BASE_LSB = 7;
  localparam int SRC_LAST = 19;
  // Writable bits of the three priority registers
  localparam logic [31:0] PA_MASK = 32'h07777070;
  localparam logic [31:0] PB_MASK = 32'h77777700;
  localparam logic [31:0] PC_MASK = 32'h00007777;
  // Reset values
  localparam logic [31:0] RST_WORD = 32'h00000000;
  localparam logic [15:0] RST_BASE = 16'h0000;
  localparam logic [1:0] RST_CTL = 2'h0;
  localparam logic [7:0] RST_NEST = 8'h00;
  typedef struct packed {
    logic [31:0] norm_en;
    logic [31:0] fast_en;
    logic swi_norm;
    logic swi_fast;
    logic [15:0] base;
    logic [31:0] pa;
    logic [31:0] pb;
    logic [31:0] pc;
    logic [1:0] ctl;
    logic [7:0] nest;
    logic [31:0] rdata;
    logic nreq;
    logic freq;
  } vimu_state_s;
endpackage : vimu_pkg

// File: src/vimu_top.sv
// Interrupt mask unit with normal and fast request lines and vectored mode
//
// Design decision made here: the address-and-strobe port.
module vimu_top (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [31:0] src_in,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rdata,
  output logic normal_req,
  output logic fast_request
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Address match for one register
  function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
    hit = (a == off);
  endfunction : hit

  // Priority field of one source; sources without a field read level 0
  function automatic logic [2:0] prio_of(input int i, input logic [31:0] pa,
                                         input logic [31:0] pb,
                                         input logic [31:0] pc);
    logic [2:0] p;
    p = 3'h0;
    unique case (i)
      1: p = pa[6:4];
      3: p = pa[14:12];
      4: p = pa[18:16];
      5: p = pa[22:20];
      6: p = pa[26:24];
      10: p = pb[10:8];
      11: p = pb[14:12];
      12: p = pb[18:16];
      13: p = pb[22:20];
      14: p = pb[26:24];
      15: p = pb[30:28];
      16: p = pc[2:0];
      17: p = pc[6:4];
      18: p = pc[10:8];
      19: p = pc[14:12];
      default: p = 3'h0;
    endcase
    prio_of = p;
  endfunction : prio_of

  ////////////////////////////////////////////////////////////////////////////
  // State

  vimu_pkg::vimu_state_s s_r;
  vimu_pkg::vimu_state_s s_nxt;

  logic [31:0] fraw;
  logic [31:0] fmsk;
  logic [31:0] nraw;
  logic [31:0] nmsk;
  logic fast_or;
  logic [2:0] lvl [vimu_pkg::SRC_LAST:0];
  logic [3:0] blk_lvl;
  logic [vimu_pkg::SRC_LAST:0] allowed;
  logic [4:0] win_idx;
  logic [2:0] win_lvl;
  logic win_any;
  logic [31:0] vec_word;
  logic [7:0] nest_low;

  ////////////////////////////////////////////////////////////////////////////
  // Status paths

  // Software bits sit in raw and masked status at once, unmasked
  always_comb begin
    fraw = {src_in[31:2], s_r.swi_fast, 1'b0};
    fmsk[31:2] = fraw[31:2] & s_r.fast_en[31:2];
    fmsk[1] = s_r.swi_fast;
    fast_or = |fmsk[31:1];
    fmsk[0] = fast_or;
    nraw = {src_in[31:2], s_r.swi_norm, fast_or};
    nmsk[31:2] = nraw[31:2] & s_r.norm_en[31:2];
    nmsk[1] = s_r.swi_norm;
    nmsk[0] = fast_or;
  end

  // Per-source levels from the priority registers
  genvar gi;
  generate
    for (gi = 0; gi <= vimu_pkg::SRC_LAST; gi++) begin : g_lvl
      assign lvl[gi] = prio_of(gi, s_r.pa, s_r.pb, s_r.pc);
    end
  endgenerate

  // Most urgent level under service; 8 means nothing is blocked
  always_comb begin
    blk_lvl = 4'h8;
    for (int k = 7; k >= 0; k--) begin
      if (s_r.nest[k]) begin
        blk_lvl = 4'(k);
      end
    end
  end

  // A source passes only if strictly more urgent than the blocked level
  always_comb begin
    allowed = '0;
    for (int i = 1; i <= vimu_pkg::SRC_LAST; i++) begin
      allowed[i] = nmsk[i] && ({1'b0, lvl[i]} < blk_lvl);
    end
  end

  // Descending scan with <= lets the lowest bit win a tie
  always_comb begin
    win_idx = 5'h00;
    win_lvl = 3'h7;
    win_any = 1'b0;
    for (int i = vimu_pkg::SRC_LAST; i >= 1; i--) begin
      if (allowed[i] && (!win_any || lvl[i] <= win_lvl)) begin
        win_idx = 5'(i);
        win_lvl = lvl[i];
        win_any = 1'b1;
      end
    end
    if (!s_r.ctl[vimu_pkg::CTL_NORM_BIT]) begin
      win_idx = 5'h00;
    end
  end

  // Vector word: zeros, base, index, zeros
  assign vec_word = {9'h000, s_r.base, win_idx, 2'h0};

  // Lowest set nesting bit; only that one may be cleared per write
  assign nest_low = s_r.nest & (~s_r.nest + 8'h01);

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_nxt = s_r;
    // Enable masks; a source never ends up enabled in both classes
    if (wr_stb && hit(addr, vimu_pkg::OFF_NEN)) begin
      s_nxt.norm_en = s_r.norm_en | wdata;
      s_nxt.fast_en = s_r.fast_en & ~wdata;
    end
    if (wr_stb && hit(addr, vimu_pkg::OFF_NCLR)) begin
      s_nxt.norm_en = s_r.norm_en & ~wdata;
    end
    if (wr_stb && hit(addr, vimu_pkg::OFF_FEN)) begin
      s_nxt.fast_en = s_r.fast_en | wdata;
      s_nxt.norm_en = s_r.norm_en & ~wdata;
    end
    if (wr_stb && hit(addr, vimu_pkg::OFF_FCLR)) begin
      s_nxt.fast_en = s_r.fast_en & ~wdata;
    end
    // Software interrupts set and clear both ways
    if (wr_stb && hit(addr, vimu_pkg::OFF_SWI)) begin
      s_nxt.swi_norm = wdata[vimu_pkg::SWI_NORM_BIT];
      s_nxt.swi_fast = wdata[vimu_pkg::SWI_FAST_BIT];
    end
    if (wr_stb && hit(addr, vimu_pkg::OFF_BASE)) begin
      s_nxt.base = wdata[15:0];
    end
    if (wr_stb && hit(addr, vimu_pkg::OFF_PA)) begin
      s_nxt.pa = wdata & vimu_pkg::PA_MASK;
    end
    if (wr_stb && hit(addr, vimu_pkg::OFF_PB)) begin
      s_nxt.pb = wdata & vimu_pkg::PB_MASK;
    end
    if (wr_stb && hit(addr, vimu_pkg::OFF_PC)) begin
      s_nxt.pc = wdata & vimu_pkg::PC_MASK;
    end
    if (wr_stb && hit(addr, vimu_pkg::OFF_CTL)) begin
      s_nxt.ctl = wdata[1:0];
    end
    // Clearing nest bits in level order keeps the stack honest
    if (wr_stb && hit(addr, vimu_pkg::OFF_NEST)) begin
      s_nxt.nest = s_r.nest & ~(nest_low & wdata[7:0]);
    end
    // A vector read in vectored mode pushes the winner's level
    if (rd_stb && hit(addr, vimu_pkg::OFF_VEC) && s_r.ctl[vimu_pkg::CTL_NORM_BIT]
        && win_any) begin
      s_nxt.nest[win_lvl] = 1'b1;
    end
    // Read data stand in the cycle after the strobe only
    s_nxt.rdata = vimu_pkg::RST_WORD;
    if (rd_stb) begin
      unique case (addr)
        vimu_pkg::OFF_NMSK: s_nxt.rdata = nmsk;
        vimu_pkg::OFF_NRAW: s_nxt.rdata = nraw;
        vimu_pkg::OFF_NEN: s_nxt.rdata = s_r.norm_en;
        vimu_pkg::OFF_BASE: s_nxt.rdata = {16'h0000, s_r.base};
        vimu_pkg::OFF_VEC: s_nxt.rdata = vec_word;
        vimu_pkg::OFF_PA: s_nxt.rdata = s_r.pa;
        vimu_pkg::OFF_PB: s_nxt.rdata = s_r.pb;
        vimu_pkg::OFF_PC: s_nxt.rdata = s_r.pc;
        vimu_pkg::OFF_CTL: s_nxt.rdata = {30'h00000000, s_r.ctl};
        vimu_pkg::OFF_NEST: s_nxt.rdata = {24'h000000, s_r.nest};
        vimu_pkg::OFF_FMSK: s_nxt.rdata = fmsk;
        vimu_pkg::OFF_FRAW: s_nxt.rdata = {fraw[31:1], fast_or};
        vimu_pkg::OFF_FEN: s_nxt.rdata = s_r.fast_en;
        default: s_nxt.rdata = vimu_pkg::RST_WORD;
      endcase
    end
    // Requests; nesting only gates the normal class
    s_nxt.freq = fast_or;
    if (s_r.ctl[vimu_pkg::CTL_NORM_BIT]) begin
      s_nxt.nreq = win_any;
    end else begin
      s_nxt.nreq = |nmsk;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_r.norm_en <= vimu_pkg::RST_WORD;
      s_r.fast_en <= vimu_pkg::RST_WORD;
      s_r.swi_norm <= 1'b0;
      s_r.swi_fast <= 1'b0;
      s_r.base <= vimu_pkg::RST_BASE;
      s_r.pa <= vimu_pkg::RST_WORD;
      s_r.pb <= vimu_pkg::RST_WORD;
      s_r.pc <= vimu_pkg::RST_WORD;
      s_r.ctl <= vimu_pkg::RST_CTL;
      s_r.nest <= vimu_pkg::RST_NEST;
      s_r.rdata <= vimu_pkg::RST_WORD;
      s_r.nreq <= 1'b0;
      s_r.freq <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata = s_r.rdata;
  assign normal_req = s_r.nreq;
  assign fast_request = s_r.freq;

endmodule : vimu_top

// File: test/vimu_src_model.sv
// Peripheral source lines driven toward the mask unit
module vimu_src_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [31:0] lines,
  output logic [31:0] src_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Lines hold until the next load, so each event outlasts detection latency
  // Bits 1:0 are ignored by the unit, so they toggle to expose any use of them
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) src_in <= 32'h00000000;
    else if (load) src_in[31:2] <= lines[31:2];
    else src_in[1:0] <= ~src_in[1:0];
  end
endmodule : vimu_src_model

// File: test/vimu_monitor.sv
// Port-level checks of the interrupt mask unit
module vimu_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [31:0] src_in,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [31:0] rdata,
  input wire logic normal_req,
  input wire logic fast_request
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  // Vectored normal mode lets nesting hold back a software request, so track it
  logic vec_on_r;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      vec_on_r <= 1'b0;
    end else if (wr_stb && addr == vimu_pkg::OFF_CTL) begin
      vec_on_r <= wdata[0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Read answers stand one cycle only
  a_rd_idle: assert property (!$past(rd_stb) |-> rdata == 32'h00000000)
    else $error("read data not idle");
  a_base_upper: assert property (rd_stb && addr == vimu_pkg::OFF_BASE
    |=> rdata[31:16] == 16'h0000)
    else $error("base upper bits set");
  a_vec_fixed: assert property (rd_stb && addr == vimu_pkg::OFF_VEC
    |=> !(|rdata[31:23]) && !(|rdata[1:0]))
    else $error("vector fixed bits set");
  a_vec_range: assert property (rd_stb && addr == vimu_pkg::OFF_VEC
    |=> rdata[6:2] <= 5'h13)
    else $error("vector index out of range");
  a_wo_zero: assert property (rd_stb && (addr == vimu_pkg::OFF_NCLR
    || addr == vimu_pkg::OFF_SWI || addr == vimu_pkg::OFF_FCLR) |=> rdata == 32'h00000000)
    else $error("write-only register read nonzero");
  ////////////////////////////////////////////////////////////////////////////
  // Fast OR ties status bit 0 to the request line
  a_fast_or: assert property (rd_stb && addr == vimu_pkg::OFF_FMSK
    |=> rdata[0] == (|rdata[31:1]) && rdata[0] == fast_request)
    else $error("fast OR mismatch");
  a_or_bit0: assert property (rd_stb && (addr == vimu_pkg::OFF_FRAW
    || addr == vimu_pkg::OFF_NMSK) |=> rdata[0] == fast_request)
    else $error("bit 0 not fast OR");
  a_raw_follow: assert property (rd_stb && (addr == vimu_pkg::OFF_FRAW
    || addr == vimu_pkg::OFF_NRAW) |=> rdata[31:2] == $past(src_in[31:2]))
    else $error("raw status not following sources");
  a_swi_norm: assert property (!vec_on_r && wr_stb
    && addr == vimu_pkg::OFF_SWI && wdata[1] |-> ##[1:2] normal_req)
    else $error("software normal request missing");
  a_swi_fast: assert property (wr_stb && addr == vimu_pkg::OFF_SWI
    && wdata[2] |-> ##[1:2] fast_request)
    else $error("software fast request missing");
endmodule : vimu_chk
bind vimu_top vimu_chk u_vimu_chk (.core_clk(core_clk), .rst(rst), .src_in(src_in),
  .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
  .normal_req(normal_req), .fast_request(fast_request));

// File: test/vimu_top_bench.sv
// Self-checking bench for the interrupt mask unit
module vimu_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] addr = 32'h0, wdata = 32'h0, lines = 32'h0, rdata, src_in;
  logic wr_stb = 1'b0, rd_stb = 1'b0, load = 1'b0, normal_req, fast_request;
  logic [31:0] nen = 32'h0, fen = 32'h0, sw = 32'h0, base = 32'h0;
  int err_count = 0;
  int samples_checked = 0;
  logic [31:0] zr[12] = '{vimu_pkg::OFF_NMSK, vimu_pkg::OFF_NEN, vimu_pkg::OFF_NCLR,
    vimu_pkg::OFF_SWI, vimu_pkg::OFF_BASE, vimu_pkg::OFF_VEC, vimu_pkg::OFF_CTL,
    vimu_pkg::OFF_NEST, vimu_pkg::OFF_FMSK, vimu_pkg::OFF_FEN, vimu_pkg::OFF_FCLR, 32'hFFFF0200};
  logic [31:0] ops[8] = '{vimu_pkg::OFF_NEN, vimu_pkg::OFF_FEN, vimu_pkg::OFF_NCLR,
    vimu_pkg::OFF_FCLR, vimu_pkg::OFF_SWI, vimu_pkg::OFF_BASE, vimu_pkg::OFF_NMSK,
    vimu_pkg::OFF_FRAW};
  always #10 core_clk = ~core_clk;
  vimu_top u_vimu_top (.core_clk(core_clk), .rst(rst), .src_in(src_in), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .normal_req(normal_req), .fast_request(fast_request));
  vimu_src_model u_vimu_src_model (.core_clk(core_clk), .rst(rst), .load(load),
    .lines(lines), .src_in(src_in));
  ////////////////////////////////////////////////////////////////////////////
  // Reference model: masks, software bits and the fast OR
  function automatic logic [31:0] fm();
    logic [31:0] f;
    f = (lines & fen & 32'hFFFFFFFC) | ((sw & 32'h4) >> 1);
    f[0] = |f[31:1];
    return f;
  endfunction : fm
  function automatic logic [31:0] nm();
    return (lines & nen & 32'hFFFFFFFC) | (sw & 32'h2) | {31'h0, |fm()};
  endfunction : nm
  // Raw status: source lines, the class's software bit s and the fast OR in bit 0
  function automatic logic [31:0] raw(input logic [31:0] s);
    return (lines & 32'hFFFFFFFC) | s | (fm() & 32'h1);
  endfunction : raw
  // Bus write; the model follows the same set and clear side effects
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge core_clk);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge core_clk);
    wr_stb <= 1'b0;
    if (a == vimu_pkg::OFF_NEN || a == vimu_pkg::OFF_FCLR) fen = fen & ~v;
    if (a == vimu_pkg::OFF_FEN || a == vimu_pkg::OFF_NCLR) nen = nen & ~v;
    if (a == vimu_pkg::OFF_NEN) nen = nen | v;
    if (a == vimu_pkg::OFF_FEN) fen = fen | v;
    if (a == vimu_pkg::OFF_SWI) sw = v & 32'h6;
    if (a == vimu_pkg::OFF_BASE) base = v & 32'hFFFF;
  endtask : wr
  task automatic chk_reg(input logic [31:0] a, input logic [31:0] e);
    @(posedge core_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge core_clk);
    rd_stb <= 1'b0;
    #1 samples_checked++;
    if (rdata !== e) begin
      err_count++;
      $display("Error at %0t addr %h exp %h got %h", $time, a, e, rdata);
    end
  endtask : chk_reg
  task automatic chk_req(input logic [1:0] e);
    samples_checked++;
    if ({normal_req, fast_request} !== e) begin
      err_count++;
      $display("Error at %0t req exp %h got %h", $time, e, {normal_req, fast_request});
    end
  endtask : chk_req
  task automatic src(input logic [31:0] v);
    lines <= v;
    load <= 1'b1;
    @(posedge core_clk);
    load <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask : src
  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////////
  // Hang guard well beyond the longest sequence
  initial begin
    #400000;
    err_count++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'hEB1EF828));
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    foreach (zr[i]) chk_reg(zr[i], 32'h0);
    // Random enables, clears, software bits and source levels
    repeat (40) begin
      wr(ops[$urandom_range(7, 0)], $urandom);
      src($urandom);
      #1 chk_req({|nm(), |fm()});
      chk_reg(vimu_pkg::OFF_NMSK, nm());
      chk_reg(vimu_pkg::OFF_FMSK, fm());
      chk_reg(vimu_pkg::OFF_NRAW, raw(sw & 32'h2));
      chk_reg(vimu_pkg::OFF_FRAW, raw((sw & 32'h4) >> 1));
      chk_reg(vimu_pkg::OFF_NEN, nen);
      chk_reg(vimu_pkg::OFF_FEN, fen);
      chk_reg(vimu_pkg::OFF_VEC, base << 7);
    end
    // Vectored mode: level order, then a tie on level
    wr(vimu_pkg::OFF_SWI, 32'h0);
    wr(vimu_pkg::OFF_NEN, 32'h408);
    src(32'h408);
    wr(vimu_pkg::OFF_PA, 32'h2000);
    wr(vimu_pkg::OFF_PB, 32'h100);
    wr(vimu_pkg::OFF_CTL, 32'h1);
    chk_reg(vimu_pkg::OFF_CTL, 32'h1);
    chk_req(2'h2);
    chk_reg(vimu_pkg::OFF_VEC, (base << 7) | 32'h28);
    chk_reg(vimu_pkg::OFF_NEST, 32'h2);
    chk_req(2'h0);
    wr(vimu_pkg::OFF_NEST, 32'hFF);
    wr(vimu_pkg::OFF_PB, 32'h200);
    chk_reg(vimu_pkg::OFF_VEC, (base << 7) | 32'hC);
    wr(vimu_pkg::OFF_NEST, 32'hFF);
    wr(vimu_pkg::OFF_CTL, 32'h0);
    chk_reg(vimu_pkg::OFF_VEC, base << 7);
    // Fast vectoring bit alone leaves the normal vector index at zero
    wr(vimu_pkg::OFF_CTL, 32'h2);
    chk_reg(vimu_pkg::OFF_CTL, 32'h2);
    chk_reg(vimu_pkg::OFF_VEC, base << 7);
    wr(vimu_pkg::OFF_PC, 32'hFFFFFFFF);
    chk_reg(vimu_pkg::OFF_PC, vimu_pkg::PC_MASK);
    end_of_test();
  end
endmodule : vimu_top_bench
